// ==== bench/epc_periph_model.sv ====
/*
 peripheral model: answers the enhanced strobes with the wait handshake.
 assumes active-low strobe levels from the engine and one pclk domain.
*/
`timescale 1ns/1ps
module epc_periph_model (
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // engine side
    input  wire logic       strb_n,
    // scenario control: 0 handshake, 1 stuck low, 2 stuck high
    input  wire logic [1:0] mode,
    input  wire logic [3:0] dly,
    input  wire logic [7:0] rd_byte,
    // pins
    output logic            busy,
    output logic      [7:0] pd_drv
);
    // ****************
    // wait handshake
    // ****************
    logic [3:0] cnt_reg;

    // wait high after setup, low again after hold, each dly+1 cycles late
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            busy    <= 1'b0;
            cnt_reg <= 4'h0;
        end
        else if (mode != 2'h0)
        begin
            busy    <= mode[1];
            cnt_reg <= 4'h0;
        end
        else if (busy == strb_n)
        begin
            cnt_reg <= cnt_reg + 4'h1;
            if (cnt_reg >= dly)
            begin
                busy    <= !strb_n;
                cnt_reg <= 4'h0;
            end
        end
        else
        begin
            cnt_reg <= 4'h0;
        end
    end

    // ****************
    // byte bus
    // ****************
    // a released bus shows the inverse, so a stale sample cannot match
    assign pd_drv = strb_n ? ~rd_byte : rd_byte;
endmodule

// ==== bench/tb_top.sv ====
/*
 self-checking bench for the cycle engine: apb, host cycles, watchdog.
 assumes the epc_pkg register offsets and the engine's 2-stage input sync.
*/
`timescale 1ns/1ps
module tb_top;
    // ****************
    // signals
    // ****************
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready, pslverr;
    logic        rd_n = 1'b1, wr_n = 1'b1, asel = 1'b0, dsel = 1'b0;
    logic [7:0]  sd_in = 8'h00, rd_byte = 8'h00, sd_out, pd_out, pd_drv;
    logic        sd_oe_n, io_oe_n, zws_n, wri_n, afd_n, sin_n, init_n, pd_oe_n, busy;
    logic [1:0]  mode = 2'h0;
    logic [3:0]  dly = 4'h0, stat = 4'h0;
    logic [16:0] note;
    logic [16:0] exp_q[$];
    int          seed = 32'h58ebc8c1;
    int          n_tests = 0, miscompares = 0, nw;
    wire  [7:0]  pd_in = pd_oe_n ? pd_drv : pd_out;
    wire  [4:0]  obs = {io_oe_n, sd_oe_n, wri_n, afd_n, sin_n};

    always #2.5 pclk = ~pclk;

    epc_engine dut_u (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .host_rd_n(rd_n), .host_wr_n(wr_n), .host_addr_sel(asel),
        .host_data_sel(dsel), .sd_in(sd_in), .sd_out(sd_out), .sd_oe_n(sd_oe_n),
        .iochrdy_out(), .iochrdy_oe_n(io_oe_n), .zero_wait_state_n(zws_n),
        .strobe_out_n(wri_n), .autofeed_out_n(afd_n), .select_in_n(sin_n),
        .init_out_n(init_n), .periph_byte_bus_in(pd_in), .periph_byte_bus_out(pd_out),
        .periph_byte_bus_oe_n(pd_oe_n), .busy_in(busy), .ack_in_n(stat[3]),
        .error_in_n(stat[2]), .slct_in(stat[1]), .paper_end_in(stat[0])
    );

    epc_periph_model peri_u (
        .pclk(pclk), .presetn(presetn), .strb_n(sin_n & afd_n), .mode(mode),
        .dly(dly), .rd_byte(rd_byte), .busy(busy), .pd_drv(pd_drv)
    );

    // ****************
    // checking
    // ****************
    task automatic check(input string what, input logic [16:0] e, input logic [16:0] g);
        n_tests++;
        if (g !== e)
        begin
            miscompares++;
            $display("BAD %s exp %h got %h", what, e, g);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // note = {slverr, mask, value}; taken off the queue when read data appears
    always @(posedge pclk)
    begin
        if (psel && penable && pready === 1'b1 && !pwrite)
        begin
            note = exp_q.pop_front();
            check("prdata", {note[16], 8'h0, note[7:0]},
                  {pslverr, 8'h0, prdata[7:0] & note[15:8]});
        end
    end

    // ****************
    // drivers
    // ****************
    task automatic wait_bit(input int b, input logic v, input int lim, output int n);
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (obs[b] !== v && n < lim);
        if (obs[b] !== v)
        begin
            $display("BAD wait on bit %0d exp %b got %b", b, v, obs[b]);
            miscompares++;
            give_verdict();
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                       input logic [16:0] nt);
        int i;
        if (!w)
            exp_q.push_back(nt);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do
        begin
            @(posedge pclk);
            i++;
        end
        while (pready !== 1'b1 && i < 50);
        if (pready !== 1'b1)
        begin
            $display("BAD apb ready missing at %h", a);
            miscompares++;
            give_verdict();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // one host cycle; the host keeps its strobe until iochrdy is released
    task automatic hcyc(input logic rd, input logic ds, input logic ezws,
                        input logic [3:0] dl, output int nw);
        logic [7:0] b;
        int         n;
        b = 8'($random(seed));
        // let the peripheral drop wait after the previous cycle first
        repeat (20) @(posedge pclk);
        dly <= dl;
        rd_byte <= b;
        sd_in <= b;
        asel <= !ds;
        dsel <= ds;
        rd_n <= !rd;
        wr_n <= rd;
        wait_bit(int'(ds), 1'b0, 40, n);
        check("strobes", {14'h0, rd, !ds, ds}, {14'h0, wri_n, afd_n, sin_n});
        if (!rd)
            check("pd", {9'h0, b}, {8'h0, pd_oe_n, pd_out});
        repeat (2) @(posedge pclk);
        check("rdy_zws", {15'h0, !ezws, ezws}, {15'h0, zws_n, io_oe_n});
        wait_bit(4, 1'b1, 3000, nw);
        repeat (3) @(posedge pclk);
        if (rd)
            check("sd", {9'h0, b}, {8'h0, sd_oe_n, sd_out});
        rd_n <= 1'b1;
        wr_n <= 1'b1;
        wait_bit(rd ? 3 : 2, 1'b1, 40, n);
        check("released", 17'hf, {13'h0, wri_n, afd_n, sin_n, sd_oe_n});
        asel <= 1'b0;
        dsel <= 1'b0;
    endtask

    // ****************
    // sequence
    // ****************
    initial
    begin
        stat = 4'($random(seed));
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, epc_pkg::PCTL_OFS, 8'h00, 17'h02f00);
        apb(1'b0, epc_pkg::CFG_OFS, 8'h00, 17'h00300);
        apb(1'b0, 8'h0c, 8'h00, 17'h1ff00);
        apb(1'b1, 8'h0c, 8'h5a, 17'h0);
        apb(1'b0, epc_pkg::PSTS_OFS, 8'h00, {9'h0f9, stat, 4'h0});
        apb(1'b1, epc_pkg::PCTL_OFS, 8'h0f, 17'h0);
        repeat (3) @(posedge pclk);
        check("idle_ctl", 17'h0, {13'h0, wri_n, afd_n, init_n, sin_n});
        apb(1'b1, epc_pkg::PCTL_OFS, 8'h00, 17'h0);
        apb(1'b1, epc_pkg::CFG_OFS, 8'h01, 17'h0);
        mode <= 2'h2;
        repeat (8) @(posedge pclk);
        mode <= 2'h0;
        repeat (8) @(posedge pclk);
        check("idle_pins", 17'h1f, {12'h0, obs});
        // dly stays far below the watchdog, so only the stuck-low case aborts
        for (int r = 0; r < 2; r++)
        begin
            apb(1'b1, epc_pkg::CFG_OFS, 8'(1 + 2 * r), 17'h0);
            for (int k = 0; k < 4; k++)
            begin
                apb(1'b1, epc_pkg::PCTL_OFS, k[0] ? 8'h20 : 8'h00, 17'h0);
                hcyc(k[0], k[1], 1'b0, 4'($random(seed)), nw);
            end
        end
        apb(1'b1, epc_pkg::MODE_OFS, 8'h80, 17'h0);
        mode <= 2'h2;
        for (int k = 0; k < 2; k++)
        begin
            apb(1'b1, epc_pkg::PCTL_OFS, k[0] ? 8'h20 : 8'h00, 17'h0);
            hcyc(k[0], 1'b0, 1'b1, 4'h0, nw);
        end
        mode <= 2'h0;
        apb(1'b1, epc_pkg::PCTL_OFS, 8'h00, 17'h0);
        hcyc(1'b0, 1'b1, 1'b0, 4'h3, nw);
        apb(1'b1, epc_pkg::MODE_OFS, 8'h00, 17'h0);
        apb(1'b1, epc_pkg::CFG_OFS, 8'h01, 17'h0);
        mode <= 2'h1;
        hcyc(1'b0, 1'b0, 1'b0, 4'h0, nw);
        check("wd_len", 17'h1,
              17'(nw > epc_pkg::WD_CYCLES - 12 && nw < epc_pkg::WD_CYCLES + 4));
        apb(1'b0, epc_pkg::PSTS_OFS, 8'h00, 17'h00101);
        mode <= 2'h0;
        apb(1'b1, epc_pkg::PSTS_OFS, 8'h01, 17'h0);
        apb(1'b0, epc_pkg::PSTS_OFS, 8'h00, 17'h00100);
        repeat (4) @(posedge pclk);
        give_verdict();
    end
endmodule

// ==== hw/epc_engine.sv ====
/*
 enhanced parallel port cycle engine with apb control registers.
 assumes isa strobes, selects, sd and all peripheral pins are asynchronous.
*/
`timescale 1ns/1ps
module epc_engine (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // isa host
    input  wire logic        host_rd_n,
    input  wire logic        host_wr_n,
    input  wire logic        host_addr_sel,
    input  wire logic        host_data_sel,
    input  wire logic [7:0]  sd_in,
    output logic      [7:0]  sd_out,
    output logic             sd_oe_n,
    output logic             iochrdy_out,
    output logic             iochrdy_oe_n,
    output logic             zero_wait_state_n,
    // peripheral
    output logic             strobe_out_n,
    output logic             autofeed_out_n,
    output logic             select_in_n,
    output logic             init_out_n,
    input  wire logic [7:0]  periph_byte_bus_in,
    output logic      [7:0]  periph_byte_bus_out,
    output logic             periph_byte_bus_oe_n,
    input  wire logic        busy_in,
    input  wire logic        ack_in_n,
    input  wire logic        error_in_n,
    input  wire logic        slct_in,
    input  wire logic        paper_end_in
);
    // ***************
    // pin synchronisers
    // ***************
    localparam int SW = 25;
    logic [SW-1:0] raw;
    logic [SW-1:0] meta_reg;
    logic [SW-1:0] sync_reg;

    assign raw = {periph_byte_bus_in, sd_in, host_rd_n, host_wr_n, host_addr_sel,
                  host_data_sel, busy_in, ack_in_n, error_in_n, slct_in, paper_end_in};

    genvar gi;
    generate
        for (gi = 0; gi < SW; gi++)
        begin : g_sync
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    meta_reg[gi] <= 1'b1;
                    sync_reg[gi] <= 1'b1;
                end
                else
                begin
                    meta_reg[gi] <= raw[gi];
                    sync_reg[gi] <= meta_reg[gi];
                end
            end
        end
    endgenerate

    logic [7:0] pd_s;
    logic [7:0] sd_s;
    logic       rd_s;
    logic       wr_s;
    logic       asel_s;
    logic       dsel_s;
    logic       wait_lo;
    logic [3:0] stat_s;

    assign pd_s    = sync_reg[24:17];
    assign sd_s    = sync_reg[16:9];
    assign rd_s    = ~sync_reg[8];
    assign wr_s    = ~sync_reg[7];
    assign asel_s  = sync_reg[6];
    assign dsel_s  = sync_reg[5];
    assign wait_lo = ~sync_reg[4];
    assign stat_s  = sync_reg[3:0];

    // ***************
    // registers and watchdog link
    // ***************
    logic [5:0] pctl_reg;
    logic [1:0] cfg_reg;
    logic       zws_en_reg;
    logic       tout_reg;
    logic       host_act;
    logic       start;
    logic       abort;
    epc_pkg::epc_state_t state, state_next;
    logic       cyc_read;
    logic       cyc_data;
    logic       cyc_on;
    logic       slow_reg;
    logic       keep_reg;
    logic       rel_reg;
    logic       pend;
    logic       apb_wr;

    epc_wd_if wdl ();

    epc_watchdog u_wd (
        .pclk    (pclk),
        .presetn (presetn),
        .wd      (wdl.tmr)
    );

    assign host_act = (rd_s || wr_s) && (asel_s || dsel_s);
    assign start    = cfg_reg[epc_pkg::CFG_EPP] && host_act;
    assign abort    = wdl.expire;
    assign cyc_on   = cyc_read ? rd_s : wr_s;
    assign pend     = rel_reg && wr_s && (asel_s || dsel_s) && cfg_reg[epc_pkg::CFG_EPP];
    // stall window: waiting on the peripheral, not on the host
    assign wdl.run  = (state == epc_pkg::ST_V17 && wait_lo)
                   || state == epc_pkg::ST_V19_SETUP || state == epc_pkg::ST_V19_STRB;

    // ***************
    // cycle sequencer
    // ***************
    always_comb
    begin
        state_next = state;
        unique case (state)
            epc_pkg::ST_IDLE:
                if (start)
                    state_next = (zws_en_reg || !cfg_reg[epc_pkg::CFG_REV19])
                               ? epc_pkg::ST_V17 : epc_pkg::ST_V19_SETUP;
            epc_pkg::ST_V17:
                if (abort)
                    state_next = epc_pkg::ST_END;
                else if (!cyc_on)
                    state_next = epc_pkg::ST_IDLE;
            epc_pkg::ST_V19_SETUP:
                if (abort)
                    state_next = epc_pkg::ST_END;
                else if (wait_lo)
                    state_next = epc_pkg::ST_V19_STRB;
            epc_pkg::ST_V19_STRB:
                if (abort)
                    state_next = epc_pkg::ST_END;
                else if (!wait_lo)
                    state_next = epc_pkg::ST_V19_HOLD;
            epc_pkg::ST_V19_HOLD:
                if (cyc_read)
                begin
                    if (!cyc_on)
                        state_next = epc_pkg::ST_IDLE;
                end
                else if (wait_lo)
                    state_next = pend ? epc_pkg::ST_V19_SETUP
                               : (rel_reg ? epc_pkg::ST_IDLE : epc_pkg::ST_END);
            epc_pkg::ST_END:
                if (!cyc_on)
                    state_next = epc_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state <= epc_pkg::ST_IDLE;
        else
            state <= state_next;
    end

    // per-cycle bookkeeping
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cyc_read <= 1'b0;
            cyc_data <= 1'b0;
            slow_reg <= 1'b0;
            keep_reg <= 1'b0;
            rel_reg  <= 1'b0;
        end
        else
        begin
            if (state == epc_pkg::ST_IDLE && start)
            begin
                cyc_read <= rd_s;
                cyc_data <= dsel_s;
                slow_reg <= 1'b0;
                rel_reg  <= 1'b0;
            end
            else if (state == epc_pkg::ST_V19_HOLD && !cyc_read && wait_lo && pend)
            begin
                cyc_data <= dsel_s;
                keep_reg <= 1'b1;
                rel_reg  <= 1'b0;
            end
            else
            begin
                if (state == epc_pkg::ST_V17 && wait_lo)
                    slow_reg <= 1'b1;
                if (state != epc_pkg::ST_V19_SETUP)
                    keep_reg <= 1'b0;
                if (!cyc_on)
                    rel_reg <= 1'b1;
            end
        end
    end

    // ***************
    // peripheral control outputs
    // ***************
    logic strb_next;
    logic wrind_next;
    logic rd_nx;
    logic keep_nx;
    logic data_nx;

    // plain nets: a continuous assign would not wake on what a function reads
    assign rd_nx      = (state == epc_pkg::ST_IDLE) ? rd_s : cyc_read;
    assign keep_nx    = (state == epc_pkg::ST_V19_HOLD) ? pend : keep_reg;
    assign data_nx    = (state == epc_pkg::ST_IDLE || state == epc_pkg::ST_V19_HOLD)
                      ? dsel_s : cyc_data;
    assign strb_next  = state_next == epc_pkg::ST_V17 || state_next == epc_pkg::ST_V19_STRB;
    assign wrind_next = !rd_nx && (state_next == epc_pkg::ST_V17
                     || state_next == epc_pkg::ST_V19_STRB || state_next == epc_pkg::ST_V19_HOLD
                     || (state_next == epc_pkg::ST_V19_SETUP && keep_nx));

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            strobe_out_n   <= 1'b1;
            autofeed_out_n <= 1'b1;
            select_in_n    <= 1'b1;
            init_out_n     <= 1'b1;
        end
        else
        begin
            init_out_n <= ~pctl_reg[epc_pkg::PCTL_INIT];
            if (state_next == epc_pkg::ST_IDLE)
            begin
                strobe_out_n   <= ~pctl_reg[epc_pkg::PCTL_WRI];
                autofeed_out_n <= ~pctl_reg[epc_pkg::PCTL_AFD];
                select_in_n    <= ~pctl_reg[epc_pkg::PCTL_SEL];
            end
            else
            begin
                strobe_out_n   <= ~wrind_next;
                autofeed_out_n <= ~(strb_next && data_nx);
                select_in_n    <= ~(strb_next && !data_nx);
            end
        end
    end

    // ***************
    // byte buses
    // ***************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            periph_byte_bus_out  <= 8'h00;
            periph_byte_bus_oe_n <= 1'b1;
            sd_out               <= 8'h00;
            sd_oe_n              <= 1'b1;
        end
        else
        begin
            if ((state == epc_pkg::ST_IDLE && start && wr_s)
                || (state == epc_pkg::ST_V19_HOLD && !cyc_read && wait_lo && pend))
                periph_byte_bus_out <= sd_s;
            if (state_next == epc_pkg::ST_IDLE)
                periph_byte_bus_oe_n <= pctl_reg[epc_pkg::PCTL_DIR];
            else
                periph_byte_bus_oe_n <= rd_nx
                                     || (state_next == epc_pkg::ST_V19_SETUP && !keep_nx);
            if (state == epc_pkg::ST_V17 || (state == epc_pkg::ST_V19_STRB && !wait_lo))
                sd_out <= pd_s;
            sd_oe_n <= !(rd_nx && state_next != epc_pkg::ST_IDLE);
        end
    end

    // ***************
    // host wait lines
    // ***************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            iochrdy_out       <= 1'b0;
            iochrdy_oe_n      <= 1'b1;
            zero_wait_state_n <= 1'b1;
        end
        else
        begin
            iochrdy_out       <= 1'b0;
            iochrdy_oe_n      <= !((state_next == epc_pkg::ST_V17 && wait_lo)
                              || state_next == epc_pkg::ST_V19_SETUP
                              || state_next == epc_pkg::ST_V19_STRB);
            zero_wait_state_n <= !(state_next == epc_pkg::ST_V17 && zws_en_reg
                              && !wait_lo && !slow_reg && state != epc_pkg::ST_IDLE);
        end
    end

    // ***************
    // apb registers
    // ***************
    logic       map_hit;
    logic [7:0] rd_val;

    assign apb_wr = psel && penable && pwrite && pready;

    always_comb
    begin
        map_hit = 1'b1;
        rd_val  = 8'h00;
        unique case (paddr)
            epc_pkg::PCTL_OFS:  rd_val = {2'b00, pctl_reg};
            epc_pkg::PSTS_OFS:  rd_val = {stat_s, sync_reg[4], 2'b00, tout_reg};
            epc_pkg::CFG_OFS:   rd_val = {6'h00, cfg_reg};
            epc_pkg::MODE_OFS:  rd_val = {zws_en_reg, 7'h00};
            default:            map_hit = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !map_hit;
            if (psel && !penable)
                prdata <= {24'h00_0000, rd_val};
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pctl_reg   <= epc_pkg::PCTL_RST;
            cfg_reg    <= epc_pkg::CFG_RST;
            zws_en_reg <= 1'b0;
        end
        else if (apb_wr)
        begin
            if (paddr == epc_pkg::PCTL_OFS)
                pctl_reg <= pwdata[5:0];
            if (paddr == epc_pkg::CFG_OFS)
                cfg_reg <= pwdata[1:0];
            if (paddr == epc_pkg::MODE_OFS)
                zws_en_reg <= pwdata[epc_pkg::MODE_ZWS];
        end
    end

    // timeout flag: write one clears, an expiry in the same cycle wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tout_reg <= 1'b0;
        else if (abort)
            tout_reg <= 1'b1;
        else if (apb_wr && paddr == epc_pkg::PSTS_OFS && pwdata[epc_pkg::PSTS_TOUT])
            tout_reg <= 1'b0;
    end

    // ***************
    // checks
    // ***************
    logic [epc_pkg::WD_W-1:0] stall_cnt;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            stall_cnt <= '0;
        else
            stall_cnt <= wdl.run ? stall_cnt + 1'b1 : '0;
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_IDLE_PCTL: assert property ((state == epc_pkg::ST_IDLE) |->
        select_in_n == ~$past(pctl_reg[epc_pkg::PCTL_SEL]))
        else $error("idle select-in does not follow port control");
    AST_WD_LIMIT: assert property (stall_cnt <= epc_pkg::WD_W'(epc_pkg::WD_CYCLES))
        else $error("stall outlived watchdog");
    AST_WD_ABORT: assert property (abort |=> state == epc_pkg::ST_END && tout_reg)
        else $error("expiry did not abort and flag");
    AST_V17_RDY: assert property ((state == epc_pkg::ST_V17 && !wait_lo) |=> iochrdy_oe_n)
        else $error("iochrdy pulled while wait high");
    AST_V17_END: assert property ((state == epc_pkg::ST_V17 && !cyc_on && !abort)
        |=> state == epc_pkg::ST_IDLE ##1 $stable(periph_byte_bus_out))
        else $error("cycle did not end with host strobe");
    AST_V19_SETUP: assert property ((state == epc_pkg::ST_V19_SETUP
        || state == epc_pkg::ST_V19_STRB) |-> !iochrdy_oe_n)
        else $error("iochrdy not held in 1.9 wait");
    AST_V19_STRB: assert property ((state == epc_pkg::ST_V19_STRB) |->
        (cyc_data ? !autofeed_out_n : !select_in_n)
        && (cyc_read || (!strobe_out_n && !periph_byte_bus_oe_n)))
        else $error("1.9 strobe phase wrong");
    AST_V19_HOLD: assert property ((state == epc_pkg::ST_V19_HOLD) |->
        iochrdy_oe_n && autofeed_out_n && select_in_n)
        else $error("1.9 hold phase wrong");
    AST_RD_LATCH: assert property ((state == epc_pkg::ST_V19_STRB && !wait_lo
        && cyc_read && !abort) |=> sd_out == $past(pd_s) && !sd_oe_n)
        else $error("1.9 read byte not latched");
    AST_ZWS: assert property (!zero_wait_state_n |-> iochrdy_oe_n
        && state == epc_pkg::ST_V17)
        else $error("zero wait with iochrdy low");
    AST_SD_IDLE: assert property ((state == epc_pkg::ST_IDLE) |-> sd_oe_n)
        else $error("sd driven while idle");
    AST_START: assert property (($past(state) == epc_pkg::ST_IDLE
        && state != epc_pkg::ST_IDLE) |-> $past(start))
        else $error("cycle began without host access");
endmodule

// ==== hw/epc_watchdog.sv ====
/*
 watchdog: counts cycles while the engine stalls on the peripheral.
 assumes run drops within a cycle of expire.
*/
`timescale 1ns/1ps
module epc_watchdog (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // engine side
    epc_wd_if.tmr     wd
);
    logic [epc_pkg::WD_W-1:0] cnt_reg;
    logic                     exp_reg;

    assign wd.expire = exp_reg;

    // count restarts whenever the stall ends, so each cycle gets the full window
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_reg <= '0;
            exp_reg <= 1'b0;
        end
        else if (!wd.run || exp_reg)
        begin
            cnt_reg <= '0;
            exp_reg <= 1'b0;
        end
        else
        begin
            cnt_reg <= cnt_reg + 1'b1;
            exp_reg <= (cnt_reg == epc_pkg::WD_W'(epc_pkg::WD_CYCLES - 2));
        end
    end
endmodule

// ==== inc/epc_pkg.sv ====
/*
 enhanced parallel port cycle engine: constants, offsets, states.
 assumes a 200 MHz pclk and byte-wide apb registers in the low bits.
*/
// Functional notes
// - two protocol revisions, picked by revision bit of register at 008h
// - with no enhanced cycle running, control outputs follow the port control register
// - watchdog starts with the host strobe; expires after 10 us without wait (the code counts rev 1.7 cycles only while wait is low)
// - on expiry the cycle aborts and printer status bit 0 is set
// - select-in is address strobe, autofeed data strobe, strobe the write indicator
// - busy input is an active-low wait that stretches host cycles via iochrdy
// - rev 1.7 address write: latch sd, drive byte, write low, then strobe
// - rev 1.7: iochrdy low while wait low; never pulled when wait high
// - rev 1.7 write end: write and strobe high before the byte may change
// - rev 1.7 read: strobe, gate byte bus onto sd, release at host end
// - at end of read sd is no longer driven
// - data cycles match address cycles using data strobe and data register
// - rev 1.9 write: after latching, pull iochrdy low and await wait low
// - rev 1.9 write on wait low: write low, drive byte, strobe, await wait high
// - rev 1.9 on wait high: release iochrdy and strobe, await wait low
// - rev 1.9 write end: write high unless another write is pending
// - rev 1.9 read: iochrdy low, strobe on wait low, latch byte on wait high
// - zero-wait-state enabled by bit 7 of port mode register, both revisions
// - zero-wait: wait high gives zws low, iochrdy high; released at host end
// - wait low before host end: iochrdy low, zws not asserted
// - zero-wait reads mirror writes with read strobe and reversed direction
package epc_pkg;
    // ***************
    // register map
    // ***************
    localparam logic [7:0] PCTL_OFS  = 8'h00;
    localparam logic [7:0] PSTS_OFS  = 8'h04;
    localparam logic [7:0] CFG_OFS   = 8'h08;
    localparam logic [7:0] MODE_OFS  = 8'h10;
    localparam int PCTL_WRI   = 0;
    localparam int PCTL_AFD   = 1;
    localparam int PCTL_INIT  = 2;
    localparam int PCTL_SEL   = 3;
    localparam int PCTL_DIR   = 5;
    localparam int CFG_EPP    = 0;
    localparam int CFG_REV19  = 1;
    localparam int MODE_ZWS   = 7;
    localparam int PSTS_TOUT  = 0;
    localparam logic [5:0] PCTL_RST = 6'h00;
    localparam logic [1:0] CFG_RST  = 2'h0;
    // ***************
    // timing
    // ***************
    localparam int CLK_PERIOD_NS = 5;
    localparam int WD_TIME_US    = 10;
    localparam int WD_CYCLES     = WD_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int WD_W          = 12;
    typedef enum logic [2:0] {
        ST_IDLE, ST_V17, ST_V19_SETUP, ST_V19_STRB, ST_V19_HOLD, ST_END
    } epc_state_t;
endpackage

// ==== inc/epc_wd_if.sv ====
/*
 link between the cycle engine and its watchdog timer.
 assumes both ends run on pclk.
*/
`timescale 1ns/1ps
interface epc_wd_if;
    logic run;
    logic expire;
    modport eng (output run, input expire);
    modport tmr (input run, output expire);
endinterface
